// *** design/global_clock_select_and_chip_id.sv ***
// Global clock select, reset cause, periodic interrupt force and chip identification
// Contract
// R1: Four read-only ID registers, id in bits 4:0
// R2: Bit 7 shows boot-pin fetch override
// R3: Bits 6:5 show boot-mode pin levels
// R4: Cause field 00 none, 01 watchdog, 11 reset
// R5: Reading control register clears cause field
// R6: Writing bit 5 one forces periodic interrupt
// R7: Bits 1:0 disable or set interrupt priority
// R8: Select 000..111 sets CPU, peripheral dividers
// R9: Codes 100/101 run from slow clock
// R10: Spreader off, normal or strong cycle jitter
// R11: Slow clock drives real-time and 2400 baud
// R12: Short or self-timed chip select by code
// R13: Short chip select only last 2 clocks
// R14: Clock select switches on clean boundary
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module global_clock_select_and_chip_id
  import gclk_pkg::*;
#(
  parameter logic [4:0] ROM_ID = 5'h0a, // Arbitrary value
  parameter logic [4:0] RAM_ID = 5'h13, // Arbitrary value
  parameter logic [4:0] CPU_ID = 5'h15, // Arbitrary value
  parameter logic [4:0] REV_ID = 5'h07, // Arbitrary value
  parameter int SLOW_HZ = SLOW_CLK_HZ,
  parameter int BAUD = BOOT_BAUD
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] boot_mode_pins_i,
  input wire logic fetch_override_i,
  input wire logic slow_clk_i,
  input wire logic watchdog_timeout_i,
  input wire logic periodic_irq_ack_i,
  input wire logic mem_cs_req_i,
  input wire logic mem_cycle_last_i,
  output logic periodic_irq_pending_o,
  output logic [1:0] periodic_irq_priority_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic main_osc_enable_o,
  output logic rtc_tick_o,
  output logic boot_baud_tick_o,
  output logic memory_cs_n_o,
  output logic self_timed_cs_o
);
  if (BAUD <= 0 || BAUD >= SLOW_HZ || SLOW_HZ > 65535) begin : g_bad_rate
    $error("Boot baud rate must be below the slow clock rate");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Three stages; a level is accepted only when stages two and three agree.
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_q;
  logic slow_q;
  wire [3:0] pins_raw = {slow_clk_i, fetch_override_i, boot_mode_pins_i};
  wire slow_tick = pin_s2[3] & pin_s3[3] & ~slow_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_q <= 4'h0;
    end else begin
      pin_s1 <= pins_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
    end
  end
  assign slow_q = pin_q[3];

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire [7:0] idx = adr_i[9:2];
  wire req = cyc_i & stb_i;
  wire take = req & ack_o;
  wire hit_gcs = idx == IDX_GCS;
  wire hit_spread = idx == IDX_SPREAD;
  wire hit_psave = idx == IDX_PSAVE;
  wire wr_lane0 = take & we_i & sel_i[0];
  wire wr_gcs = wr_lane0 & hit_gcs;
  wire rd_gcs = take & ~we_i & hit_gcs;

  logic [1:0] cause, prio, spread_mode;
  logic [2:0] sel_field, active_sel;
  logic short_cs_en;
  wire [2:0] id_top = {pin_q[2], pin_q[1:0]};

  logic [7:0] rd_byte;
  always_comb begin
    unique case (idx)
      IDX_GCS: rd_byte = {cause, 1'b0, sel_field, prio}; // R6
      IDX_ROM_ID: rd_byte = {id_top, ROM_ID}; // R1 R2 R3
      IDX_RAM_ID: rd_byte = {id_top, RAM_ID}; // R1
      IDX_CPU_ID: rd_byte = {id_top, CPU_ID}; // R1
      IDX_REV_ID: rd_byte = {id_top, REV_ID}; // R1
      IDX_SPREAD: rd_byte = {6'h00, spread_mode};
      IDX_PSAVE: rd_byte = {3'h0, short_cs_en, 4'h0};
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: ack rises the cycle after the request, for one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o & ~we_i) begin
        dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  wire [1:0] next_cause = (rd_gcs ? CAUSE_NONE : cause) |
                          (watchdog_timeout_i ? CAUSE_WDOG : CAUSE_NONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= CAUSE_RESET; // R4
      prio <= PRIO_RESET;
      sel_field <= SEL_RESET;
      spread_mode <= SPREAD_OFF;
      short_cs_en <= 1'b0;
      periodic_irq_pending_o <= 1'b0;
    end else begin
      // Watchdog in the read cycle survives; OR keeps code 10 unreachable.
      cause <= next_cause; // R4 R5
      periodic_irq_pending_o <= (wr_gcs & dat_i[GCS_FORCE_BIT]) |
                                (periodic_irq_pending_o & ~periodic_irq_ack_i); // R6
      if (wr_gcs) begin
        prio <= dat_i[1:0]; // R7
        sel_field <= dat_i[GCS_SEL_LSB +: 3]; // R8
      end
      if (wr_lane0 & hit_spread) begin
        spread_mode <= dat_i[1:0]; // R10
      end
      if (wr_lane0 & hit_psave) begin
        short_cs_en <= dat_i[PSAVE_SHORT_BIT]; // R12
      end
    end
  end
  assign periodic_irq_priority_o = prio; // R7

  // ---------------------------------------------------------------
  // Clock dividers
  // ---------------------------------------------------------------
  function automatic logic [3:0] div_of(input logic [2:0] s);
    unique case (s)
      SEL_OSC1: div_of = 4'h1;
      SEL_OSC2: div_of = 4'h2;
      SEL_OSC4: div_of = 4'h4;
      SEL_OSC6: div_of = 4'h6;
      SEL_SLOW_ON, SEL_SLOW_OFF: div_of = 4'h0;
      default: div_of = 4'h8;
    endcase
  endfunction

  function automatic logic is_slow(input logic [2:0] s);
    is_slow = (s == SEL_SLOW_ON) || (s == SEL_SLOW_OFF);
  endfunction

  logic [3:0] cnt;
  logic phase;
  // The reload uses the requested code, so the first period after a switch
  // already has the new length and no runt or stretched pulse appears.
  // A slow code reloads 4'hf; the count then idles until the next slow tick.
  wire [3:0] div = div_of(sel_field);
  wire slow_mode = is_slow(active_sel);
  // Spreading needs headroom below the divisor; osc/1 cannot be spread.
  wire [3:0] step = (spread_mode == SPREAD_STRONG && div >= 4'h4) ? SPREAD_STRONG_STEP :
                    (spread_mode != SPREAD_OFF && spread_mode != 2'h3 && div >= 4'h2) ?
                    SPREAD_NORMAL_STEP : 4'h0;
  wire [3:0] base = div - 4'h1;
  wire [3:0] next_cnt = phase ? base + step : base - step; // R10
  wire cpu_en = slow_mode ? slow_tick : (cnt == 4'h0); // R8 R9

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_sel <= SEL_RESET;
      cnt <= 4'h0;
      phase <= 1'b0;
    end else if (cpu_en) begin
      // New code only at the end of a whole divided period.
      active_sel <= sel_field; // R14
      cnt <= next_cnt; // R14
      phase <= ~phase & (step != 4'h0); // R10
    end else if (!slow_mode) begin
      cnt <= cnt - 4'h1;
    end
  end

  assign cpu_clk_en_o = cpu_en; // R8
  assign periph_clk_en_o = (active_sel == SEL_CPU8_PER1) | cpu_en; // R8
  assign main_osc_enable_o = active_sel != SEL_SLOW_OFF; // R9

  // ---------------------------------------------------------------
  // Slow clock consumers
  // ---------------------------------------------------------------
  // Fractional accumulator keeps the average baud exact.
  logic [16:0] baud_acc;
  wire [16:0] acc_sum = baud_acc + 17'(BAUD);
  wire acc_wrap = acc_sum >= 17'(SLOW_HZ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_acc <= 17'h0_0000;
      rtc_tick_o <= 1'b0;
      boot_baud_tick_o <= 1'b0;
    end else begin
      rtc_tick_o <= slow_tick; // R11
      boot_baud_tick_o <= slow_tick & acc_wrap; // R11
      if (slow_tick) begin
        baud_acc <= acc_wrap ? acc_sum - 17'(SLOW_HZ) : acc_sum;
      end
    end
  end

  // ---------------------------------------------------------------
  // Chip select power save
  // ---------------------------------------------------------------
  wire short_code = (active_sel == SEL_OSC8) | (active_sel == SEL_CPU8_PER1) |
                    (active_sel == SEL_OSC4) | (active_sel == SEL_OSC6);
  wire short_active = short_cs_en & short_code; // R12
  wire cs_window = mem_cycle_last_i & (cnt < SHORT_CS_CLOCKS); // R13
  assign memory_cs_n_o = ~(mem_cs_req_i & (~short_active | cs_window)); // R13
  assign self_timed_cs_o = short_cs_en & slow_mode; // R12

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_id_low_bits: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (req && !ack_o && !we_i && idx == IDX_CPU_ID) |=> dat_o[4:0] == CPU_ID)
    else $error("CPU id field wrong");
  a_id_pin_bits: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    (req && !ack_o && !we_i && idx == IDX_REV_ID) |=> dat_o[6:5] == $past(pin_q[1:0]))
    else $error("Boot pin bits wrong");
  a_id_fetch_bit: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (req && !ack_o && !we_i && idx == IDX_ROM_ID) |=> dat_o[7] == $past(pin_q[2]))
    else $error("Fetch override bit wrong");
  a_cause_legal: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (cause != 2'h2) and (watchdog_timeout_i |=> cause[0]))
    else $error("Illegal reset cause");
  a_cause_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (rd_gcs && !watchdog_timeout_i) |=> cause == CAUSE_NONE)
    else $error("Cause not cleared by read");
  a_force_irq: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (wr_gcs && dat_i[GCS_FORCE_BIT]) |=> periodic_irq_pending_o
      ##1 (!$past(rd_gcs) || !dat_o[GCS_FORCE_BIT]))
    else $error("Forced interrupt not pending");
  a_prio_write: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    wr_gcs |=> periodic_irq_priority_o == $past(dat_i[1:0]))
    else $error("Priority not written");
  a_div2_rate: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (cpu_en && active_sel == SEL_OSC2 && sel_field == SEL_OSC2 && step == 4'h0)
      |=> !cpu_en ##1 cpu_en)
    else $error("osc/2 rate wrong");
  a_slow_source: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (slow_mode && cpu_en) |-> slow_tick && (main_osc_enable_o == (active_sel != SEL_SLOW_OFF)))
    else $error("Slow mode enable not from slow clock");
  a_baud_tick: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    boot_baud_tick_o |-> rtc_tick_o)
    else $error("Baud tick without slow clock edge");
  a_short_cs: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (!memory_cs_n_o && short_active) |-> mem_cycle_last_i && cnt <= 4'h1)
    else $error("Short chip select too wide");
  a_clean_switch: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    $changed(active_sel) |-> $past(cpu_en))
    else $error("Clock select changed mid period");

  // ---------------------------------------------------------------
  // Bus, register, divider, slow tick, pin and chip select checks
  // ---------------------------------------------------------------
  // Bus answers are single pulses; a held ack would repeat a read-clear.
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    ack_o
      |=> !ack_o)
    else $error("Ack longer than one cycle");
  a_rd_upper: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    ack_o
      |-> dat_o[31:8] == 24'h00_0000)
    else $error("Read data upper bytes not zero");
  a_force_reads0: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (req && !ack_o && !we_i && idx == IDX_GCS)
      |=> !dat_o[GCS_FORCE_BIT])
    else $error("Force bit read back as one");
  a_cause_read: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (req && !ack_o && !we_i && idx == IDX_GCS)
      |=> dat_o[7:6] == $past(cause))
    else $error("Cause field not reported");
  a_sel_write: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    wr_gcs
      |=> sel_field == $past(dat_i[GCS_SEL_LSB +: 3]))
    else $error("Clock select not written");
  a_prio_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    !wr_gcs
      |=> $stable(periodic_irq_priority_o))
    else $error("Priority changed without write");
  a_pending_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (periodic_irq_pending_o && !periodic_irq_ack_i)
      |=> periodic_irq_pending_o)
    else $error("Pending interrupt lost");
  a_osc_off: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    !main_osc_enable_o
      |-> slow_mode)
    else $error("Oscillator off outside slow mode");
  a_per_full: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (active_sel == SEL_CPU8_PER1)
      |-> periph_clk_en_o)
    else $error("Peripheral clock not at full rate");
  a_rtc_tick: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    slow_tick
      |=> rtc_tick_o)
    else $error("Slow clock edge without tick");
  a_self_timed: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    self_timed_cs_o
      |-> slow_mode && short_cs_en)
    else $error("Self-timed select outside slow mode");
  a_short_code: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    short_active
      |-> !slow_mode && active_sel != SEL_OSC1 && active_sel != SEL_OSC2)
    else $error("Short select with wrong code");
  // Per bit: the other pin may still be settling when one bit moves.
  a_pin_agree: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    $changed(pin_q[0])
      |-> $past(pin_s2[0] == pin_s3[0]))
    else $error("Boot pin accepted before stages agree");
  a_fetch_agree: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    $changed(pin_q[2])
      |-> $past(pin_s2[2] == pin_s3[2]))
    else $error("Fetch flag accepted before stages agree");
  a_reload: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    cpu_en
      |=> cnt == $past(next_cnt))
    else $error("Divider not reloaded at boundary");
  a_slow_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (slow_mode && !cpu_en)
      |=> cnt == $past(cnt))
    else $error("Divider runs in slow mode");
endmodule

// *** common/gclk_pkg.sv ***
// Constants shared by the global clock select and identification block
package gclk_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_GCS = 8'h00;
  localparam logic [7:0] IDX_ROM_ID = 8'h2c;
  localparam logic [7:0] IDX_RAM_ID = 8'h2d;
  localparam logic [7:0] IDX_CPU_ID = 8'h2e;
  localparam logic [7:0] IDX_REV_ID = 8'h2f;
  localparam logic [7:0] IDX_SPREAD = 8'h30;
  localparam logic [7:0] IDX_PSAVE = 8'h31;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GCS_FORCE_BIT = 5;
  localparam int GCS_SEL_LSB = 2;
  localparam int PSAVE_SHORT_BIT = 4;
  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_WDOG = 2'h1;
  localparam logic [1:0] CAUSE_RESET = 2'h3;
  localparam logic [2:0] SEL_OSC8 = 3'h0;
  localparam logic [2:0] SEL_CPU8_PER1 = 3'h1;
  localparam logic [2:0] SEL_OSC1 = 3'h2;
  localparam logic [2:0] SEL_OSC2 = 3'h3;
  localparam logic [2:0] SEL_SLOW_ON = 3'h4;
  localparam logic [2:0] SEL_SLOW_OFF = 3'h5;
  localparam logic [2:0] SEL_OSC4 = 3'h6;
  localparam logic [2:0] SEL_OSC6 = 3'h7;
  localparam logic [2:0] SEL_RESET = SEL_OSC8;
  localparam logic [1:0] PRIO_RESET = 2'h0;
  localparam logic [1:0] SPREAD_OFF = 2'h0;
  localparam logic [1:0] SPREAD_NORMAL = 2'h1;
  localparam logic [1:0] SPREAD_STRONG = 2'h2;
  localparam logic [3:0] SPREAD_NORMAL_STEP = 4'h1;
  localparam logic [3:0] SPREAD_STRONG_STEP = 4'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SLOW_CLK_HZ = 32768;
  localparam int BOOT_BAUD = 2400;
  localparam logic [3:0] SHORT_CS_CLOCKS = 4'h2;
endpackage

// *** verif/tb_global_clock_select_and_chip_id.sv ***
// Self-checking bench for the global clock select and identification block
`timescale 1ns/1ps
module tb_global_clock_select_and_chip_id;
  import gclk_pkg::*;
  localparam logic [4:0] T_ID [4] = '{5'h0a, 5'h13, 5'h15, 5'h07}; // Arbitrary values
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, fetch_override_i = 0;
  logic slow_clk_i = 0, watchdog_timeout_i = 0, periodic_irq_ack_i = 0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o;
  logic [1:0] boot_mode_pins_i = '0, periodic_irq_priority_o;
  logic ack_o, periodic_irq_pending_o, cpu_clk_en_o, periph_clk_en_o, main_osc_enable_o;
  logic rtc_tick_o, memory_cs_n_o, boot_baud_tick_o, self_timed_cs_o;
  logic mem_cs_req_i = 0, mem_cycle_last_i = 0;
  int failures = 0, num_checks = 0, n, i, m;
  logic [7:0] q;
  global_clock_select_and_chip_id #(.ROM_ID(T_ID[0]), .RAM_ID(T_ID[1]), .CPU_ID(T_ID[2]),
    .REV_ID(T_ID[3])) global_clock_select_and_chip_id_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .boot_mode_pins_i(boot_mode_pins_i),
    .fetch_override_i(fetch_override_i), .slow_clk_i(slow_clk_i),
    .watchdog_timeout_i(watchdog_timeout_i), .periodic_irq_ack_i(periodic_irq_ack_i),
    .mem_cs_req_i(mem_cs_req_i), .mem_cycle_last_i(mem_cycle_last_i),
    .periodic_irq_pending_o(periodic_irq_pending_o),
    .periodic_irq_priority_o(periodic_irq_priority_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .main_osc_enable_o(main_osc_enable_o),
    .rtc_tick_o(rtc_tick_o), .boot_baud_tick_o(boot_baud_tick_o),
    .memory_cs_n_o(memory_cs_n_o), .self_timed_cs_o(self_timed_cs_o));
  // ---------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    forever #15259 slow_clk_i = ~slow_clk_i;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  // Classic single cycle; cyc/stb held until ack is sampled, then dropped
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] r);
    int k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    r = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    if (k >= 50) begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
      conclude();
    end
  endtask
  // Cycles from one CPU enable pulse to the next
  task automatic gap(output int k);
    k = 0;
    while (cpu_clk_en_o !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (cpu_clk_en_o !== 1'b1 && k < 20);
  endtask
  task automatic period(input logic [2:0] c, input int exp);
    logic [7:0] r;
    int k;
    wb(1, IDX_GCS, {3'b000, c, 2'b00}, r);
    repeat (10) @(negedge clk_i);
    gap(k);
    chk_byte(8'(k), 8'(exp));
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    // Rows: identification reads under changing pins; writes must be ignored
    for (i = 0; i < 5; i++) begin
      boot_mode_pins_i <= 2'(i + 1);
      fetch_override_i <= i[0];
      wb(1, (i < 4) ? IDX_ROM_ID + 8'(i) : 8'h3f, 8'hff, q);
      repeat (6) @(posedge clk_i);
      wb(0, (i < 4) ? IDX_ROM_ID + 8'(i) : 8'h3f, 8'h00, q);
      chk_byte(q, (i < 4) ? {i[0], 2'(i + 1), T_ID[i]} : 8'h00);
    end
    wb(0, IDX_GCS, 8'h00, q);
    chk_byte(q, 8'hc0);
    wb(0, IDX_GCS, 8'h00, q);
    chk_byte(q, 8'h00);
    @(posedge clk_i) watchdog_timeout_i <= 1;
    @(posedge clk_i) watchdog_timeout_i <= 0;
    wb(0, IDX_GCS, 8'h00, q);
    chk_byte(q, 8'h40);
    chk_bit(periodic_irq_pending_o, 0);
    wb(1, IDX_GCS, 8'h2a, q);
    @(negedge clk_i);
    chk_bit(periodic_irq_pending_o, 1);
    chk_byte({6'h0, periodic_irq_priority_o}, 8'h02);
    wb(0, IDX_GCS, 8'h00, q);
    chk_byte(q, 8'h0a);
    @(posedge clk_i) periodic_irq_ack_i <= 1;
    @(posedge clk_i) periodic_irq_ack_i <= 0;
    wb(1, IDX_GCS, 8'h0b, q);
    repeat (2) @(negedge clk_i);
    chk_bit(periodic_irq_pending_o, 0);
    chk_byte({6'h0, periodic_irq_priority_o}, 8'h03);
    period(SEL_OSC8, 8);
    period(SEL_OSC1, 1);
    period(SEL_OSC2, 2);
    period(SEL_OSC4, 4);
    period(SEL_OSC6, 6);
    period(SEL_CPU8_PER1, 8);
    for (i = 0; i < 4; i++) begin
      @(negedge clk_i);
      chk_bit(periph_clk_en_o, 1);
    end
    chk_bit(memory_cs_n_o, 1);
    // Normal spreading at osc/4 alternates periods of 3 and 5
    wb(1, IDX_SPREAD, 8'h01, q);
    wb(1, IDX_GCS, {3'b000, SEL_OSC4, 2'b00}, q);
    repeat (12) @(negedge clk_i);
    gap(n);
    gap(m);
    chk_byte(8'(n + m), 8'h08);
    chk_bit(n != 4, 1'b1);
    wb(0, IDX_SPREAD, 8'h00, q);
    chk_byte(q, 8'h01);
    wb(1, IDX_SPREAD, 8'h00, q);
    mem_cs_req_i <= 1;
    mem_cycle_last_i <= 1;
    @(negedge clk_i);
    chk_bit(memory_cs_n_o, 0);
    wb(1, IDX_PSAVE, 8'h10, q);
    m = 0;
    repeat (8) begin
      @(negedge clk_i);
      if (memory_cs_n_o === 1'b0) m++;
    end
    chk_byte(8'(m), 8'h04);
    @(posedge clk_i) mem_cycle_last_i <= 0;
    repeat (6) @(negedge clk_i);
    chk_bit(memory_cs_n_o, 1);
    @(posedge clk_i) mem_cs_req_i <= 0;
    wb(1, IDX_GCS, {3'b000, SEL_SLOW_ON, 2'b00}, q);
    repeat (20) @(negedge clk_i);
    chk_bit(main_osc_enable_o, 1);
    wb(1, IDX_GCS, {3'b000, SEL_SLOW_OFF, 2'b00}, q);
    // The new code applies only at the next slow tick
    n = 0;
    while (main_osc_enable_o !== 1'b0 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    chk_bit(main_osc_enable_o, 0);
    chk_bit(self_timed_cs_o, 1);
    n = 0;
    while (rtc_tick_o !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    chk_bit(rtc_tick_o, 1);
    n = 0;
    while (boot_baud_tick_o !== 1'b1 && n < 50000) begin
      @(negedge clk_i);
      n++;
    end
    chk_bit(boot_baud_tick_o, 1);
    chk_bit(rtc_tick_o, 1);
    @(posedge clk_i) rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wb(0, IDX_GCS, 8'h00, q);
    chk_byte(q, 8'hc0);
    chk_bit(main_osc_enable_o, 1);
    conclude();
  end
endmodule
